// ===== src/dpcs_pkg.sv
/*
  constants for the program counter sample block: register map, state codes, reset values.
  assumes a 32-bit apb register bus with byte addressing.
*/
package dpcs_pkg;
  localparam logic [11:0] PC_SAMPLE_OFFSET = 12'h000;
  localparam logic [11:0] SAMPLE_CTRL_OFFSET = 12'h004;
  localparam logic [11:0] SAMPLE_STATUS_OFFSET = 12'h008;
  localparam logic [31:0] PC_SAMPLE_RESET = 32'h0000_0000;
  localparam int ADDR_MSB = 31;
  localparam int ADDR_LSB = 2;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  typedef enum logic [1:0] {
    DPCS_ST_PRIMARY = 2'b00,
    DPCS_ST_COMPACT = 2'b01,
    DPCS_ST_BYTECODE = 2'b10,
    DPCS_ST_ENVCOMPACT = 2'b11
  } dpcs_state_e;
endpackage : dpcs_pkg

// ===== src/dpcs_capture.sv
/*
  capture stage: latches branch target address and target execution state.
  assumes branch inputs come from core logic on the same clock.
*/
`timescale 1ns/1ps
module dpcs_capture (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic branch_valid_i,
  input wire logic [31:0] branch_target_i,
  input wire logic [1:0] target_state_i,
  output logic [31:0] sample_o,
  output logic captured_o
);
  logic [31:0] sample_reg;
  logic [31:0] sample_next;
  logic captured_reg;
  logic captured_next;

  always_comb begin
    sample_next = sample_reg;
    captured_next = 1'b0;
    if (enable_i && branch_valid_i) begin
      // no pipeline offset is added to the target
      sample_next = {branch_target_i[dpcs_pkg::ADDR_MSB:dpcs_pkg::ADDR_LSB], target_state_i};
      captured_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sample_reg <= dpcs_pkg::PC_SAMPLE_RESET;
      captured_reg <= 1'b0;
    end else begin
      sample_reg <= sample_next;
      captured_reg <= captured_next;
    end
  end

  assign sample_o = sample_reg;
  assign captured_o = captured_reg;

  a_capture_value: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    enable_i && branch_valid_i |=> sample_reg == {$past(branch_target_i[31:2]), $past(target_state_i)})
    else $error("sample does not hold branch target and state");
  a_state_bits: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    enable_i && branch_valid_i |=> sample_reg[1:0] == $past(target_state_i))
    else $error("sample low bits differ from target state");
  a_hold_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(enable_i && branch_valid_i) |=> $stable(sample_reg))
    else $error("sample changed without a branch");
endmodule : dpcs_capture

// ===== src/dpcs_top.sv
/*
  program counter sample register with apb slave access.
  assumes branch retirement signals come from core logic on CLK_I.
*/
// Design decisions made here: the APB slave port and the placing of the registers.
// Summary of operation
// - the sample register captures the target address of each executed branch, possibly still speculative.
// - bits 31:2 hold the branch target address with no offset added.
// - bits 1:0 hold the target state: 00 primary, 01 compact, 10 bytecode, 11 environment compact.
// - for compact code on half-word boundaries bit 1 shows state, not address, and readers allow for it.
`timescale 1ns/1ps
module dpcs_top (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic BRANCH_VALID_I,
  input wire logic [31:0] BRANCH_TARGET_I,
  input wire logic [1:0] TARGET_STATE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O
);
  logic [31:0] sample;
  logic captured;
  logic enable_reg;
  logic enable_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic setup;

  dpcs_capture u_capture (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .enable_i(enable_reg),
    .branch_valid_i(BRANCH_VALID_I),
    .branch_target_i(BRANCH_TARGET_I),
    .target_state_i(TARGET_STATE_I),
    .sample_o(sample),
    .captured_o(captured)
  );

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == dpcs_pkg::PC_SAMPLE_OFFSET) || (a == dpcs_pkg::SAMPLE_CTRL_OFFSET) ||
             (a == dpcs_pkg::SAMPLE_STATUS_OFFSET);
  endfunction : mapped

  // no wait state: answer in the cycle after setup
  assign setup = PSEL_I && !PENABLE_I;

  always_comb begin
    enable_next = enable_reg;
    count_next = captured ? count_reg + 16'h0001 : count_reg;
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    if (setup) begin
      pready_next = 1'b1;
      pslverr_next = !mapped(PADDR_I) || (PWRITE_I && PADDR_I != dpcs_pkg::SAMPLE_CTRL_OFFSET);
      if (!PWRITE_I) begin
        // reads are pure: nothing in the core or capture path changes
        unique case (PADDR_I)
          dpcs_pkg::PC_SAMPLE_OFFSET: prdata_next = sample;
          dpcs_pkg::SAMPLE_CTRL_OFFSET: prdata_next = {31'h0, enable_reg};
          dpcs_pkg::SAMPLE_STATUS_OFFSET: prdata_next = {16'h0, count_reg};
          default: prdata_next = 32'h0000_0000;
        endcase
      end
    end
    // write commits at the access edge, when pready is high
    if (PSEL_I && PENABLE_I && pready_reg && PWRITE_I && PADDR_I == dpcs_pkg::SAMPLE_CTRL_OFFSET) begin
      enable_next = PWDATA_I[dpcs_pkg::CTRL_ENABLE_BIT];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      enable_reg <= dpcs_pkg::CTRL_ENABLE_RESET;
      count_reg <= dpcs_pkg::COUNT_RESET;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      count_reg <= count_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign PRDATA_O = prdata_reg;
  assign PREADY_O = pready_reg;
  assign PSLVERR_O = pslverr_reg;

  // bus and branch steps are named once and shared by the checks below
  sequence s_setup_read_sample;
    PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == dpcs_pkg::PC_SAMPLE_OFFSET;
  endsequence

  sequence s_setup_write_ctrl;
    PSEL_I && !PENABLE_I && PWRITE_I && PADDR_I == dpcs_pkg::SAMPLE_CTRL_OFFSET;
  endsequence

  sequence s_access;
    PSEL_I && PENABLE_I;
  endsequence

  sequence s_branch_taken;
    enable_reg && BRANCH_VALID_I;
  endsequence

  a_read_latest: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_setup_read_sample |=> PREADY_O && PRDATA_O == $past(sample))
    else $error("read did not return latest sample");

  a_read_pure: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (s_setup_read_sample and !BRANCH_VALID_I) |=> $stable(sample))
    else $error("reading changed the sample");

  a_ready_one: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    PREADY_O |=> !PREADY_O)
    else $error("pready held longer than one cycle");

  a_ready_answer: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("no answer in the cycle after setup");

  a_ready_quiet: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !(PSEL_I && !PENABLE_I) |=> !PREADY_O)
    else $error("pready raised without a setup");

  a_err_with_ready: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !PREADY_O |-> !PSLVERR_O)
    else $error("error shown outside an answer");

  a_err_one: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    PSLVERR_O |=> !PSLVERR_O)
    else $error("error held longer than one cycle");

  a_err_unmapped: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    PSEL_I && !PENABLE_I && !PWRITE_I && !mapped(PADDR_I) |=> PSLVERR_O && PRDATA_O == 32'h0000_0000)
    else $error("unmapped read not refused");

  a_err_read_only: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    PSEL_I && !PENABLE_I && PWRITE_I && PADDR_I != dpcs_pkg::SAMPLE_CTRL_OFFSET |=> PSLVERR_O)
    else $error("write to a read-only word not refused");

  a_err_none: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    PSEL_I && !PENABLE_I && mapped(PADDR_I) && (!PWRITE_I || PADDR_I == dpcs_pkg::SAMPLE_CTRL_OFFSET) |=> !PSLVERR_O)
    else $error("legal access refused");

  // a write leaves read data alone, so a stale word cannot pose as a fresh answer
  a_write_quiet: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    PSEL_I && !PENABLE_I && PWRITE_I |=> $stable(PRDATA_O))
    else $error("write disturbed read data");

  a_ctrl_write: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_setup_write_ctrl ##1 s_access |=> enable_reg == $past(PWDATA_I[dpcs_pkg::CTRL_ENABLE_BIT]))
    else $error("control write did not land");

  a_ctrl_hold: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !(PSEL_I && PENABLE_I && PWRITE_I) |=> $stable(enable_reg))
    else $error("control changed without a write");

  a_read_ctrl: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == dpcs_pkg::SAMPLE_CTRL_OFFSET
      |=> PRDATA_O[31:1] == 31'h0 && PRDATA_O[0] == $past(enable_reg))
    else $error("control read wrong");

  a_read_status: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == dpcs_pkg::SAMPLE_STATUS_OFFSET
      |=> PRDATA_O[31:16] == 16'h0000 && PRDATA_O[15:0] == $past(count_reg))
    else $error("status read wrong");

  // the count wraps silently; software must read it often enough to see every lap
  a_count_step: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    captured |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("count did not step on a capture");

  a_count_hold: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !captured |=> $stable(count_reg))
    else $error("count moved without a capture");

  a_branch_seen: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_branch_taken |=> sample[31:2] == $past(BRANCH_TARGET_I[31:2]) ##1 count_reg == $past(count_reg) + 16'h0001)
    else $error("branch target not captured");

  a_branch_refused: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !enable_reg && BRANCH_VALID_I |=> !captured)
    else $error("branch captured while disabled");

  a_no_offset: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_branch_taken ##1 !BRANCH_VALID_I ##1 s_setup_read_sample |=> PRDATA_O[31:2] == $past(BRANCH_TARGET_I[31:2], 3))
    else $error("sampled address altered");

  a_half_word: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    enable_reg && BRANCH_VALID_I && BRANCH_TARGET_I[1] && TARGET_STATE_I == 2'b01 |=> sample[1:0] == 2'b01)
    else $error("bit 1 did not carry state");

  a_word_boundary: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    enable_reg && BRANCH_VALID_I && !BRANCH_TARGET_I[1] && TARGET_STATE_I == dpcs_pkg::DPCS_ST_ENVCOMPACT
      |=> sample[1:0] == 2'b11)
    else $error("bit 1 did not carry state on a word boundary");

  a_state_code: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    enable_reg && BRANCH_VALID_I && TARGET_STATE_I == dpcs_pkg::DPCS_ST_BYTECODE |=> sample[1:0] == 2'b10)
    else $error("state code wrong");

  a_state_primary: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    enable_reg && BRANCH_VALID_I && TARGET_STATE_I == dpcs_pkg::DPCS_ST_PRIMARY |=> sample[1:0] == 2'b00)
    else $error("primary state code wrong");

  a_disabled_hold: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !enable_reg |=> $stable(sample))
    else $error("sample changed while disabled");
endmodule : dpcs_top

// ===== tb/dpcs_debugger.sv
/*
  debugger model: apb master that reads and writes the sample block.
  assumes the slave raises pready on a rising edge of clk_i.
*/
`timescale 1ns/1ps
module dpcs_debugger (
  input wire logic clk_i,
  input wire logic pready_i,
  input wire logic [31:0] prdata_i,
  input wire logic pslverr_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0;
  end
  // data is taken whole: no offset removed, low bits kept as state
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    // the slave sets its own pace: only the bench watchdog ends this wait
    @(posedge clk_i);
    while (pready_i !== 1'b1) @(posedge clk_i);
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask : xfer
endmodule : dpcs_debugger

// ===== tb/test_dpcs_top.sv
/*
  bench for dpcs_top: drives branches, reads samples through the debugger model.
  assumes a 100 MHz clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module test_dpcs_top;
  logic clk = 1'b0, rst_n = 1'b0, bv = 1'b0, psel, pen, pwr, rdy, err, e;
  logic [31:0] bt = 32'h0, rd, pwd, prd;
  logic [1:0] bs = 2'b00;
  logic [11:0] pa;
  int failures = 0, total_checks = 0;
  always #5 clk = ~clk;
  dpcs_top u_dut (.CLK_I(clk), .RST_N_I(rst_n), .BRANCH_VALID_I(bv), .BRANCH_TARGET_I(bt),
    .TARGET_STATE_I(bs), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa),
    .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err));
  dpcs_debugger u_dbg (.clk_i(clk), .pready_i(rdy), .prdata_i(prd), .pslverr_i(err),
    .psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(pa), .pwdata_o(pwd));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x,
                     input logic xe);
    u_dbg.xfer(w, a, d, rd, e);
    if (!w) check("prdata", rd, x);
    check("pslverr", {31'h0, e}, {31'h0, xe});
  endtask : acc
  task automatic branch(input logic [31:0] t, input logic [1:0] s);
    @(posedge clk);
    bv <= 1'b1;
    bt <= t;
    bs <= s;
    @(posedge clk);
    bv <= 1'b0;
  endtask : branch
  task automatic give_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial begin
    #20000;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    acc(1'b0, 12'h000, 32'h0, dpcs_pkg::PC_SAMPLE_RESET, 1'b0);
    acc(1'b0, 12'h004, 32'h0, {31'h0, dpcs_pkg::CTRL_ENABLE_RESET}, 1'b0);
    acc(1'b0, 12'h008, 32'h0, {16'h0, dpcs_pkg::COUNT_RESET}, 1'b0);
    $display("test reset done");
    // target bit 1 set while state bit 1 may be clear: state must win
    for (int i = 0; i < 4; i++) begin
      branch(32'h8000_0007 + (i << 4), 2'(i));
      repeat (2) acc(1'b0, 12'h000, 32'h0, {bt[31:2], 2'(i)}, 1'b0);
    end
    acc(1'b0, 12'h008, 32'h0, 32'h4, 1'b0);
    $display("test capture done");
    acc(1'b1, 12'h004, 32'h0, 32'h0, 1'b0);
    acc(1'b0, 12'h004, 32'h0, 32'h0, 1'b0);
    branch(32'hffff_fff0, 2'b00);
    acc(1'b0, 12'h000, 32'h0, 32'h8000_0037, 1'b0);
    acc(1'b0, 12'h008, 32'h0, 32'h4, 1'b0);
    acc(1'b1, 12'h000, 32'h1, 32'h0, 1'b1);
    acc(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
    acc(1'b0, 12'h000, 32'h0, 32'h8000_0037, 1'b0);
    $display("test refuse done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    acc(1'b0, 12'h000, 32'h0, dpcs_pkg::PC_SAMPLE_RESET, 1'b0);
    acc(1'b0, 12'h004, 32'h0, {31'h0, dpcs_pkg::CTRL_ENABLE_RESET}, 1'b0);
    // word-aligned target with the environment compact state: bit 1 shows state
    branch(32'h0000_1000, 2'b11);
    acc(1'b0, 12'h000, 32'h0, 32'h0000_1003, 1'b0);
    acc(1'b0, 12'h008, 32'h0, 32'h1, 1'b0);
    $display("test restart done");
    give_verdict();
  end
endmodule : test_dpcs_top
